//--- hdl/lcd_decoder_pkg.sv
// constants and types shared by the character display instruction decoder
package lcd_decoder_pkg;

  // clock and oscillator rates
  localparam int clk_khz        = 250000;
  localparam int osc_khz        = 80;
  localparam int osc_div_clocks = clk_khz / osc_khz;

  // documented times in microseconds
  localparam int t_reset_low_us  = 1200;
  localparam int t_reset_busy_us = 10000;
  localparam int t_clear_us      = 1630;
  localparam int t_short_us      = 125;
  localparam int t_long_us       = 175;

  // times in oscillator cycles, busy times rounded up
  localparam int          reset_low_osc  = t_reset_low_us * osc_khz / 1000;
  localparam logic [9:0]  reset_busy_osc = 10'((t_reset_busy_us * osc_khz + 999) / 1000);
  localparam logic [9:0]  clear_osc      = 10'((t_clear_us * osc_khz + 999) / 1000);
  localparam logic [9:0]  short_osc      = 10'((t_short_us * osc_khz + 999) / 1000);
  localparam logic [9:0]  long_osc       = 10'((t_long_us * osc_khz + 999) / 1000);

  // apb byte offsets
  localparam logic [11:0] off_instruction = 12'h000;
  localparam logic [11:0] off_data        = 12'h004;

  // text ram addressing
  localparam logic [6:0]  home_addr   = 7'h00;
  localparam logic [6:0]  line0_last  = 7'h0B;
  localparam logic [6:0]  line1_first = 7'h40;
  localparam logic [6:0]  line1_last  = 7'h4B;
  localparam logic [6:0]  clear_last  = 7'h7F;
  localparam logic [7:0]  space_code  = 8'h20;

  // mode values after any reset
  localparam logic        display_on_rst   = 1'b0;
  localparam logic        cursor_on_rst    = 1'b0;
  localparam logic        blink_on_rst     = 1'b0;
  localparam logic        bus_width_8_rst  = 1'b1;
  localparam logic        step_up_rst      = 1'b1;
  localparam logic        shift_entry_rst  = 1'b0;

  typedef enum logic {st_ready, st_read_wait} access_state_type;

endpackage : lcd_decoder_pkg

//--- hdl/lcd_instruction_decoder.sv
// instruction decoder of a character display controller, host side over apb
//
// Contract
// - reset pin low longer than 1.2ms starts reset; shorter pulses ignored
// - after reset pin rises, busy for 10ms and refuse instructions
// - instruction latch and data latch, chosen by target_select, with direction
// - execution times counted in 80kHz oscillator cycles
// - code 01h clears display, address counter to zero, busy 1.63ms
// - return home: address counter zero, undo shift, busy 125us
// - entry mode: bit1 step direction, bit0 shift on entry, 125us
// - display control: display, cursor, blink enables, 125us
// - move: bit3 display or cursor, bit2 right, busy 175us
// - function set: bit4 selects 8 or 4 bits; host sets bit3
// - set glyph ram location, later data go to glyph ram, 125us
// - set text ram location, later data go to text ram, 125us
// - status read gives busy flag and address counter, no busy time
// - data write stores at address counter, 8 or 5 bits, 125us
// - data read returns ram at address counter, busy 175us
// - one address counter for both rams, last set picks target
// - clear fills text ram with space code, forces increment
// - shift on entry: text write shifts display left or right
//
// Added by the designer: the APB register port and the register offsets.
module lcd_instruction_decoder #(
  parameter int osc_div = lcd_decoder_pkg::osc_div_clocks
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // hardware reset pin
  input  wire logic        reset_pin_n,
  // display state
  output logic             busy_flag,
  output logic [6:0]       address_counter,
  output logic             glyph_target,
  output logic             display_on,
  output logic             cursor_on,
  output logic             blink_on,
  output logic             bus_width_select,
  output logic             step_up,
  output logic             shift_on_entry,
  output logic [6:0]       display_offset
);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up,
                                           input logic glyph);
    logic [6:0] r;
    r = a;
    if (glyph) begin
      r = {2'h0, (up ? 5'(a[4:0] + 5'h01) : 5'(a[4:0] - 5'h01))};
    end else if (up) begin
      r = (a == lcd_decoder_pkg::line0_last) ? lcd_decoder_pkg::line1_first :
          (a == lcd_decoder_pkg::line1_last) ? lcd_decoder_pkg::home_addr :
          7'(a + 7'h01);
    end else begin
      r = (a == lcd_decoder_pkg::home_addr)   ? lcd_decoder_pkg::line1_last :
          (a == lcd_decoder_pkg::line1_first) ? lcd_decoder_pkg::line0_last :
          7'(a - 7'h01);
    end
    return r;
  endfunction : step_addr

  lcd_decoder_pkg::access_state_type state;

  logic [11:0] osc_cnt;
  logic [9:0]  busy_cnt;
  logic        rp_meta;
  logic        rp_sync;
  logic        rp_prev;
  logic [6:0]  low_cnt;
  logic        clear_active;
  logic [6:0]  clear_addr;
  logic [7:0]  text_rdata;
  logic [4:0]  glyph_rdata;

  // oscillator enable and reset pin edge
  wire         osc_tick    = (osc_cnt == 12'(osc_div - 1));
  wire         pin_rise    = rp_sync & ~rp_prev;
  wire         reset_start = pin_rise & (low_cnt > 7'(lcd_decoder_pkg::reset_low_osc));

  // apb decode
  wire         access    = psel & penable & ~pready & (state == lcd_decoder_pkg::st_ready);
  wire         hit_instr = (paddr == lcd_decoder_pkg::off_instruction);
  wire         hit_data  = (paddr == lcd_decoder_pkg::off_data);
  wire         allowed   = ~busy_flag & ~reset_start;
  wire         status_rd = access & hit_instr & ~pwrite;
  wire         instr_wr  = access & hit_instr & pwrite & allowed;
  wire         data_wr   = access & hit_data & pwrite & allowed;
  wire         data_rd   = access & hit_data & ~pwrite & allowed;
  wire         refused   = access & ~status_rd & ~instr_wr & ~data_wr & ~data_rd;
  wire         read_done = (state == lcd_decoder_pkg::st_read_wait);
  wire [7:0]   cmd       = pwdata[7:0];

  // instruction class by highest set bit
  wire         is_zero   = (cmd == 8'h00);
  wire         is_clear  = (cmd == 8'h01);
  wire         is_home   = (cmd[7:1] == 7'h01);
  wire         is_entry  = (cmd[7:2] == 6'h01);
  wire         is_ctrl   = (cmd[7:3] == 5'h01);
  wire         is_move   = (cmd[7:4] == 4'h1);
  wire         is_func   = (cmd[7:5] == 3'h1);
  wire         is_gaddr  = (cmd[7:6] == 2'h1);
  wire         is_taddr  = cmd[7];

  // busy time to load, zero when nothing starts
  wire [9:0]   exec_osc =
    reset_start ? lcd_decoder_pkg::reset_busy_osc :
    (instr_wr & is_clear) ? lcd_decoder_pkg::clear_osc :
    (instr_wr & is_move) ? lcd_decoder_pkg::long_osc :
    (instr_wr & ~is_zero) ? lcd_decoder_pkg::short_osc :
    data_wr ? lcd_decoder_pkg::short_osc :
    data_rd ? lcd_decoder_pkg::long_osc : 10'h000;

  // address counter next value
  wire [6:0]   next_ac =
    reset_start ? lcd_decoder_pkg::home_addr :
    (instr_wr & (is_clear | is_home)) ? lcd_decoder_pkg::home_addr :
    (instr_wr & is_move & ~cmd[3]) ?
      step_addr(address_counter, cmd[2], glyph_target) :
    (instr_wr & is_gaddr) ? {2'h0, cmd[4:0]} :
    (instr_wr & is_taddr) ? cmd[6:0] :
    (data_wr | read_done) ? step_addr(address_counter, step_up, glyph_target) :
    address_counter;

  // display shift counts left shifts
  wire [6:0]   offset_left  = 7'(display_offset + 7'h01);
  wire [6:0]   offset_right = 7'(display_offset - 7'h01);
  wire [6:0]   next_offset =
    (reset_start | (instr_wr & (is_clear | is_home))) ? 7'h00 :
    (instr_wr & is_move & cmd[3]) ? (cmd[2] ? offset_right : offset_left) :
    (data_wr & ~glyph_target & shift_on_entry) ?
      (step_up ? offset_left : offset_right) : display_offset;

  // ram ports, clear walk owns text ram while clear_active, the first 128 clocks of busy
  wire         text_we    = clear_active | (data_wr & ~glyph_target);
  wire [6:0]   text_waddr = clear_active ? clear_addr : address_counter;
  wire [7:0]   text_wdata = clear_active ? lcd_decoder_pkg::space_code : cmd;
  wire         glyph_we   = data_wr & glyph_target;

  small_ram #(.width(8), .depth(128), .addr_w(7)) text_ram (
    .clk   (pclk),
    .we    (text_we),
    .waddr (text_waddr),
    .wdata (text_wdata),
    .raddr (address_counter),
    .rdata (text_rdata)
  );

  small_ram #(.width(5), .depth(32), .addr_w(5)) glyph_ram (
    .clk   (pclk),
    .we    (glyph_we),
    .waddr (address_counter[4:0]),
    .wdata (cmd[4:0]),
    .raddr (address_counter[4:0]),
    .rdata (glyph_rdata)
  );

  // reset pin synchroniser and low-time counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rp_meta <= 1'b1;
      rp_sync <= 1'b1;
      rp_prev <= 1'b1;
    end else begin
      rp_meta <= reset_pin_n;
      rp_sync <= rp_meta;
      rp_prev <= rp_sync;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt <= 7'h00;
    end else if (rp_sync & rp_prev) begin
      low_cnt <= 7'h00;
    end else if (~rp_sync & osc_tick &
                 (low_cnt <= 7'(lcd_decoder_pkg::reset_low_osc))) begin
      low_cnt <= 7'(low_cnt + 7'h01);
    end
  end

  // oscillator divider and busy timer, divider restarts with each load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_cnt   <= 12'h000;
      busy_cnt  <= 10'h000;
      busy_flag <= 1'b0;
    end else if (exec_osc != 10'h000) begin
      osc_cnt   <= 12'h000;
      busy_cnt  <= exec_osc;
      busy_flag <= 1'b1;
    end else begin
      osc_cnt <= osc_tick ? 12'h000 : 12'(osc_cnt + 12'h001);
      if (osc_tick && busy_cnt != 10'h000) begin
        busy_cnt  <= 10'(busy_cnt - 10'h001);
        busy_flag <= (busy_cnt != 10'h001);
      end
    end
  end

  // text ram fill with space code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_active <= 1'b0;
      clear_addr   <= 7'h00;
    end else if (reset_start | (instr_wr & is_clear)) begin
      clear_active <= 1'b1;
      clear_addr   <= 7'h00;
    end else if (clear_active) begin
      clear_addr   <= 7'(clear_addr + 7'h01);
      clear_active <= (clear_addr != lcd_decoder_pkg::clear_last);
    end
  end

  // address counter and display shift
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      address_counter <= lcd_decoder_pkg::home_addr;
      display_offset  <= 7'h00;
    end else begin
      address_counter <= next_ac;
      display_offset  <= next_offset;
    end
  end

  // mode registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      display_on       <= lcd_decoder_pkg::display_on_rst;
      cursor_on        <= lcd_decoder_pkg::cursor_on_rst;
      blink_on         <= lcd_decoder_pkg::blink_on_rst;
      bus_width_select <= lcd_decoder_pkg::bus_width_8_rst;
      step_up          <= lcd_decoder_pkg::step_up_rst;
      shift_on_entry   <= lcd_decoder_pkg::shift_entry_rst;
      glyph_target     <= 1'b0;
    end else if (reset_start) begin
      {display_on, cursor_on, blink_on, bus_width_select} <=
        {lcd_decoder_pkg::display_on_rst, lcd_decoder_pkg::cursor_on_rst,
         lcd_decoder_pkg::blink_on_rst, lcd_decoder_pkg::bus_width_8_rst};
      {step_up, shift_on_entry, glyph_target} <=
        {lcd_decoder_pkg::step_up_rst, lcd_decoder_pkg::shift_entry_rst, 1'b0};
    end else if (instr_wr) begin
      if (is_clear) begin
        step_up      <= 1'b1;
        glyph_target <= 1'b0;
      end
      if (is_home) begin
        glyph_target <= 1'b0;
      end
      if (is_entry) begin
        step_up        <= cmd[1];
        shift_on_entry <= cmd[0];
      end
      if (is_ctrl) begin
        display_on <= cmd[2];
        cursor_on  <= cmd[1];
        blink_on   <= cmd[0];
      end
      if (is_func) begin
        bus_width_select <= cmd[4];
      end
      if (is_gaddr) begin
        glyph_target <= 1'b1;
      end
      if (is_taddr) begin
        glyph_target <= 1'b0;
      end
    end
  end

  // apb answer, data reads wait one cycle for ram
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= lcd_decoder_pkg::st_ready;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      if (access && data_rd) begin
        state <= lcd_decoder_pkg::st_read_wait;
      end else if (access) begin
        pready  <= 1'b1;
        pslverr <= refused;
        prdata  <= status_rd ? {24'h00_0000, busy_flag, address_counter}
                             : 32'h0000_0000;
      end else if (read_done) begin
        state  <= lcd_decoder_pkg::st_ready;
        pready <= 1'b1;
        prdata <= glyph_target ? {27'h000_0000, glyph_rdata}
                               : {24'h00_0000, text_rdata};
      end
    end
  end

  a_reset_accept: assert property (
    (pin_rise && low_cnt > 7'(lcd_decoder_pkg::reset_low_osc)) |=>
      busy_flag && busy_cnt == lcd_decoder_pkg::reset_busy_osc && clear_active)
    else $error("long reset pulse did not start the reset sequence");

  a_short_pulse: assert property (
    (pin_rise && low_cnt <= 7'(lcd_decoder_pkg::reset_low_osc) && !busy_flag &&
     exec_osc == 10'h000) |=> !busy_flag)
    else $error("short reset pulse was taken as a reset");

  a_busy_refuse: assert property (
    (busy_flag && psel && penable && !pready && pwrite &&
     state == lcd_decoder_pkg::st_ready) |=> pready && pslverr && $stable(display_on))
    else $error("write accepted while busy");

  a_osc_scaled: assert property (
    (busy_cnt != 10'h000 && !osc_tick && exec_osc == 10'h000) |=>
      busy_cnt == $past(busy_cnt) && busy_flag)
    else $error("busy timer moved without an oscillator tick");

  a_clear_cmd: assert property (
    (instr_wr && cmd == 8'h01) |=> address_counter == 7'h00 && step_up &&
      busy_cnt == lcd_decoder_pkg::clear_osc && clear_active && clear_addr == 7'h00)
    else $error("clear display had wrong effect");

  a_home_cmd: assert property (
    (instr_wr && cmd[7:1] == 7'h01) |=> address_counter == 7'h00 &&
      display_offset == 7'h00 && busy_cnt == lcd_decoder_pkg::short_osc)
    else $error("return home had wrong effect");

  a_entry_cmd: assert property (
    (instr_wr && cmd[7:2] == 6'h01) |=>
      step_up == $past(pwdata[1]) && shift_on_entry == $past(pwdata[0]))
    else $error("entry mode not stored");

  a_ctrl_cmd: assert property (
    (instr_wr && cmd[7:3] == 5'h01) |=>
      {display_on, cursor_on, blink_on} == $past(pwdata[2:0]))
    else $error("display control not stored");

  a_glyph_addr: assert property (
    (instr_wr && cmd[7:6] == 2'h1) |=>
      glyph_target && address_counter == {2'h0, $past(pwdata[4:0])})
    else $error("glyph ram location not loaded");

  a_status_read: assert property (
    status_rd |=> pready && !pslverr && prdata[7] == $past(busy_flag) &&
      prdata[6:0] == $past(address_counter))
    else $error("status read returned wrong value");

  a_data_read: assert property (
    data_rd |=> !pready ##1 (pready && busy_flag))
    else $error("data read answer timing wrong");

  a_entry_shift: assert property (
    (data_wr && !glyph_target && shift_on_entry) |=> display_offset ==
      ($past(step_up) ? 7'($past(display_offset) + 7'h01)
                      : 7'($past(display_offset) - 7'h01)))
    else $error("display did not shift on text write");

endmodule : lcd_instruction_decoder

//--- hdl/small_ram.sv
// simple one-write one-read memory with registered read data
module small_ram #(
  parameter int width  = 8,
  parameter int depth  = 128,
  parameter int addr_w = 7
) (
  // clock
  input  wire logic              clk,
  // write port
  input  wire logic              we,
  input  wire logic [addr_w-1:0] waddr,
  input  wire logic [width-1:0]  wdata,
  // read port
  input  wire logic [addr_w-1:0] raddr,
  output logic      [width-1:0]  rdata
);

  logic [width-1:0] mem [depth];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : small_ram

//--- testbench/host_model.sv
// host side model: apb master and hardware reset pin driver
module host_model (
  // clock
  input  wire logic        pclk,
  // apb master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // reset pin
  output logic             reset_pin_n
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h000;
    pwdata      = 32'h00000000;
    reset_pin_n = 1'b1;
  end

  // one transfer; setup cycle, then access phase held until pready, returns prdata and pslverr
  task automatic access(input logic wr, input logic [11:0] a, input logic [7:0] d,
                        output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : access

  // low pulse on the reset pin, length in clocks
  task automatic pin_pulse(input int n);
    @(posedge pclk);
    reset_pin_n <= 1'b0;
    repeat (n) @(posedge pclk);
    reset_pin_n <= 1'b1;
  endtask : pin_pulse
endmodule : host_model

//--- testbench/tb.sv
// self-checking bench of the instruction decoder
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int od = 4;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        reset_pin_n;
  logic        busy_flag;
  logic [6:0]  address_counter;
  logic        glyph_target;
  logic        display_on;
  logic        cursor_on;
  logic        blink_on;
  logic        bus_width_select;
  logic        step_up;
  logic        shift_on_entry;
  logic [6:0]  display_offset;
  int          n_errors;
  int          cmp_count;
  logic [31:0] rd;
  logic        err;

  host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reset_pin_n(reset_pin_n));

  lcd_instruction_decoder #(.osc_div(od)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .reset_pin_n(reset_pin_n),
    .busy_flag(busy_flag), .address_counter(address_counter),
    .glyph_target(glyph_target), .display_on(display_on), .cursor_on(cursor_on),
    .blink_on(blink_on), .bus_width_select(bus_width_select), .step_up(step_up),
    .shift_on_entry(shift_on_entry), .display_offset(display_offset));

  always #2 pclk = ~pclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  // accepted transfer, then busy length in clocks checked against n osc cycles
  task automatic op(input logic wr, input logic [11:0] a, input logic [7:0] d, input int n);
    int c;
    // data read answers one cycle after its busy time starts
    c = (!wr && a == 12'h004) ? 1 : 0;
    host.access(wr, a, d, rd, err);
    chk(err, 1'b0, "slave error");
    while (busy_flag === 1'b1 && c < 2000) begin
      @(posedge pclk);
      c++;
    end
    chk(c, n * od, "busy length");
  endtask : op

  // poll status until idle
  task automatic wait_idle;
    int k;
    rd = 32'h00000080;
    for (k = 0; k < 2000 && rd[7] !== 1'b0; k++) host.access(1'b0, 12'h000, 8'h00, rd, err);
    chk(rd[7], 1'b0, "still busy");
  endtask : wait_idle

  task automatic t_reset_pin;
    host.pin_pulse(80 * od);
    repeat (10) @(posedge pclk);
    chk(busy_flag, 1'b0, "short pulse reset");
    host.pin_pulse(120 * od);
    repeat (10) @(posedge pclk);
    chk(busy_flag, 1'b1, "reset busy");
    host.access(1'b1, 12'h000, 8'h0C, rd, err);
    chk(err, 1'b1, "write during reset");
    host.access(1'b0, 12'h000, 8'h00, rd, err);
    chk({err, rd[7]}, 2'b01, "status in reset");
    repeat (3000) @(posedge pclk);
    chk(busy_flag, 1'b1, "reset busy long");
    wait_idle();
    chk({glyph_target, address_counter}, 8'h00, "ac after reset");
    op(1'b0, 12'h004, 8'h00, 14);
    chk(rd, 32'h00000020, "filled space");
  endtask : t_reset_pin

  task automatic t_modes;
    op(1'b1, 12'h000, 8'h04, 10);
    chk({step_up, shift_on_entry}, 2'b00, "entry mode");
    op(1'b1, 12'h000, 8'h0D, 10);
    chk({display_on, cursor_on, blink_on}, 3'b101, "display ctl");
    op(1'b1, 12'h000, 8'h28, 10);
    chk(bus_width_select, 1'b0, "width 4");
    op(1'b1, 12'h000, 8'h38, 10);
    chk(bus_width_select, 1'b1, "width 8");
    op(1'b1, 12'h000, 8'h01, 131);
    chk({step_up, address_counter}, 8'h80, "clear");
  endtask : t_modes

  task automatic t_ram;
    op(1'b1, 12'h000, 8'h8B, 10);
    op(1'b1, 12'h004, 8'h41, 10);
    chk(address_counter, 7'h40, "text step");
    op(1'b1, 12'h000, 8'h8B, 10);
    op(1'b0, 12'h004, 8'h00, 14);
    chk(rd, 32'h00000041, "text read");
    op(1'b1, 12'h000, 8'h43, 10);
    chk({glyph_target, address_counter}, 8'h83, "glyph set");
    op(1'b1, 12'h004, 8'hFF, 10);
    op(1'b1, 12'h000, 8'h43, 10);
    op(1'b0, 12'h004, 8'h00, 14);
    chk(rd, 32'h0000001F, "glyph read");
    op(1'b0, 12'h000, 8'h00, 0);
    chk(rd, 32'h00000004, "status");
    op(1'b1, 12'h000, 8'h80, 10);
    chk(glyph_target, 1'b0, "text target");
  endtask : t_ram

  task automatic t_shift;
    op(1'b1, 12'h000, 8'h07, 10);
    op(1'b1, 12'h004, 8'h30, 10);
    chk(display_offset, 7'h01, "entry shift");
    op(1'b1, 12'h000, 8'h18, 14);
    chk(display_offset, 7'h02, "display left");
    op(1'b1, 12'h000, 8'h1C, 14);
    chk(display_offset, 7'h01, "display right");
    op(1'b1, 12'h000, 8'h03, 10);
    chk({display_offset, address_counter}, 14'h0000, "home");
    op(1'b0, 12'h004, 8'h00, 14);
    chk(rd, 32'h00000030, "home keeps text");
    op(1'b1, 12'h000, 8'h10, 14);
    chk({display_offset, address_counter}, 14'h0000, "cursor left");
    host.access(1'b1, 12'h008, 8'h01, rd, err);
    chk(err, 1'b1, "unmapped");
  endtask : t_shift

  initial begin
    pclk      = 1'b0;
    presetn   = 1'b0;
    n_errors  = 0;
    cmp_count = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset_pin();
    t_modes();
    t_ram();
    t_shift();
    report_and_stop();
  end

  initial begin
    repeat (40000) @(posedge pclk);
    n_errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    report_and_stop();
  end
endmodule : tb
